// ### dv/usc_far_end.sv
// far-end serial device: frame capture and byte sender
`timescale 1ns/1ps
`default_nettype none
module usc_far_end #(
	parameter int BIT_CYC = 1736
) (
	input wire logic ref_clk,
	input wire logic serial_txd,
	output logic serial_rxd
);
	int frames = 0;
	logic [9:0] cap = 10'h000;
	int i;
	initial serial_rxd = 1'b1;
	//------------------------------------------------------------
	// capture: centre of each bit after the start, lsb first
	//------------------------------------------------------------
	initial begin
		forever begin
			@(posedge ref_clk);
			if (serial_txd === 1'b0) begin
				repeat (BIT_CYC / 2) @(posedge ref_clk);
				for (i = 0; i < 10; i++) begin
					repeat (BIT_CYC) @(posedge ref_clk);
					cap[i] = serial_txd;
				end
				frames++;
			end
		end
	end
	// sender: 8N1, line left high after the stop bit
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		int k;
		fr = {1'b1, b, 1'b0};
		for (k = 0; k < 10; k++) begin
			serial_rxd <= fr[k];
			repeat (BIT_CYC) @(posedge ref_clk);
		end
	endtask
endmodule // usc_far_end
`default_nettype wire

// ### dv/usc_top_asserts.sv
// port assertions for the user serial channel
`timescale 1ns/1ps
`default_nettype none
module usc_top_asserts import usc_pkg::*; #(
	parameter int MS_CYCLES = USC_MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [USC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic serial_txd
);
	// fastest rate gives the shortest legal low run on the line
	localparam int BIT_MIN = 1736;
	logic [15:0] low_run;
	always_ff @(posedge ref_clk) begin
		if (!rstn || serial_txd) begin
			low_run <= 16'h0000;
		end else if (low_run != 16'hFFFF) begin
			low_run <= low_run + 16'h0001;
		end
	end
	//------------------------------------------------------------
	// properties
	//------------------------------------------------------------
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence b_taken;
		s_axi_bvalid && s_axi_bready;
	endsequence
	a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer not held");
	a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer not held");
	a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_ready_back: assert property (b_taken |=> !s_axi_bvalid ##[0:2] s_axi_awready)
		else $error("write path not freed");
	a_bad_read: assert property (ar_taken ##0 (s_axi_araddr > USC_OFS_INFO) |=>
		s_axi_rresp == USC_RESP_SLVERR && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");
	a_good_read: assert property (ar_taken ##0 (s_axi_araddr <= USC_OFS_INFO &&
		s_axi_araddr[1:0] == 2'h0) |=> s_axi_rresp == USC_RESP_OKAY)
		else $error("mapped read refused");
	a_bit_length: assert property ($rose(serial_txd) |-> low_run >= BIT_MIN)
		else $error("line low shorter than a bit");
endmodule // usc_top_asserts
`default_nettype wire

// ### dv/usc_top_test.sv
// self-checking bench for the user serial channel
`timescale 1ns/1ps
`default_nettype none
module usc_top_test import usc_pkg::*; ;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cts_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic serial_txd, serial_rxd, rts_n, irq;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	int err_total = 0, checks_done = 0;
	logic [31:0] rd;
	logic [1:0] rs;
	always #2.5 ref_clk = ~ref_clk;
	// short millisecond keeps gap timers cheap in simulation
	usc_top #(.MS_CYCLES(20)) u_usc_top (.ref_clk(ref_clk), .rstn(rstn),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .serial_rxd(serial_rxd),
		.serial_txd(serial_txd), .cts_n(cts_n), .rts_n(rts_n), .irq(irq));
	usc_far_end u_usc_far_end (.ref_clk(ref_clk), .serial_txd(serial_txd),
		.serial_rxd(serial_rxd));
	//------------------------------------------------------------
	// reporting and bus tasks
	//------------------------------------------------------------
	task complete_run();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task tmo(input string what);
		err_total++;
		$display("mismatch %s expected answer seen timeout", what);
		complete_run();
	endtask
	// ready is raised only after the answer shows, so the hold path is exercised
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
		if (n == 64) tmo("write");
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge ref_clk);
	endtask
	task rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
		if (n == 64) tmo("read");
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
	endtask
	//------------------------------------------------------------
	// scenarios
	//------------------------------------------------------------
	task t_reset();
		rdr(USC_OFS_FORMAT, rd, rs);
		chk("format reset", USC_RST_FORMAT, rd);
		rdr(USC_OFS_DUPLEX, rd, rs);
		chk("duplex reset", USC_RST_DUPLEX, rd);
		rdr(USC_OFS_FLOW, rd, rs);
		chk("flow reset", USC_RST_FLOW, rd);
		rdr(8'h3C, rd, rs);
		chk("bad read resp", {30'h0, USC_RESP_SLVERR}, {30'h0, rs});
		chk("bad read data", 32'h00000000, rd);
		wr(8'h3C, 32'hFFFFFFFF, rs);
		chk("bad write resp", {30'h0, USC_RESP_SLVERR}, {30'h0, rs});
		chk("rts idle", 32'h0, {31'h0, rts_n});
		$display("test reset done");
	endtask
	// 8N1 with reserved bits set, 7E1, 8O1; no flow control at 115.2 kbps
	task t_tx();
		logic [31:0] fmt [3];
		logic [7:0] dat [3];
		logic [9:0] frm [3];
		int i, f, n;
		fmt = '{32'h5810FF01, 32'h57120001, 32'h58110001};
		dat = '{8'hA5, 8'h37, 8'h5B};
		frm = '{10'h3A5, 10'h3B7, 10'h25B};
		wr(USC_OFS_MASK, 32'h00000002, rs);
		wr(USC_OFS_CTRL, 32'h00000001, rs);
		for (i = 0; i < 3; i++) begin
			wr(USC_OFS_FORMAT, fmt[i], rs);
			f = u_usc_far_end.frames;
			wr(USC_OFS_TXDATA, {24'h0, dat[i]}, rs);
			for (n = 0; n < 25000 && u_usc_far_end.frames == f; n++) @(posedge ref_clk);
			if (n == 25000) tmo("frame");
			chk("frame bits", {22'h0, frm[i]}, {22'h0, u_usc_far_end.cap});
			for (n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge ref_clk);
			chk("irq set", 32'h1, {31'h0, irq});
			rdr(USC_OFS_STATUS, rd, rs);
			chk("tx done flag", 32'h2, rd & 32'h2);
			wr(USC_OFS_STATUS, 32'h00000002, rs);
			chk("irq clear", 32'h0, {31'h0, irq});
		end
		$display("test tx done");
	endtask
	task t_rx();
		wr(USC_OFS_FORMAT, 32'h58100001, rs);
		u_usc_far_end.send_byte(8'h5A);
		repeat (4) @(posedge ref_clk);
		rdr(USC_OFS_RXDATA, rd, rs);
		chk("rx byte", 32'h15A, rd & 32'h1FF);
		rdr(USC_OFS_STATUS, rd, rs);
		chk("rx flag", 32'h1, rd & 32'h1);
		$display("test rx done");
	endtask
	// half duplex with clear-to-send checking: held data waits for the line
	task t_cts();
		int f, n, lows;
		lows = 0;
		cts_n <= 1'b1;
		wr(USC_OFS_DUPLEX, 32'h00001100, rs);
		f = u_usc_far_end.frames;
		wr(USC_OFS_TXDATA, 32'h0000003C, rs);
		for (n = 0; n < 1000; n++) begin
			@(posedge ref_clk);
			if (serial_txd !== 1'b1) lows++;
		end
		chk("cts held lows", 32'h0, lows);
		cts_n <= 1'b0;
		for (n = 0; n < 25000 && u_usc_far_end.frames == f; n++) @(posedge ref_clk);
		if (n == 25000) tmo("cts frame");
		chk("cts frame bits", 32'h33C, {22'h0, u_usc_far_end.cap});
		$display("test cts done");
	endtask
	// unused channel: data written must never reach the line
	task t_off();
		int f, n, lows;
		lows = 0;
		wr(USC_OFS_FORMAT, 32'h58100000, rs);
		f = u_usc_far_end.frames;
		wr(USC_OFS_TXDATA, 32'h00000011, rs);
		for (n = 0; n < 2000; n++) begin
			@(posedge ref_clk);
			if (serial_txd !== 1'b1) lows++;
		end
		chk("idle lows", 32'h0, lows);
		chk("idle frames", f, u_usc_far_end.frames);
		rdr(USC_OFS_INFO, rd, rs);
		chk("held data", 32'h100, rd & 32'h300);
		$display("test off done");
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		t_reset();
		t_tx();
		t_rx();
		t_cts();
		t_off();
		complete_run();
	end
endmodule // usc_top_test
bind usc_top usc_top_asserts #(.MS_CYCLES(MS_CYCLES)) u_usc_top_asserts (
	.ref_clk(ref_clk), .rstn(rstn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .serial_txd(serial_txd));
`default_nettype wire

// ### hdl/usc_pkg.sv
// constants and types for the user serial channel
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
package usc_pkg;
	localparam int USC_CLK_HZ = 200_000_000;
	localparam int USC_CLK_PERIOD_NS = 5;
	localparam int USC_MS_NS = 1_000_000;
	localparam int USC_MS_CYCLES = USC_MS_NS / USC_CLK_PERIOD_NS;
	localparam int USC_BAUD0 = 9600;
	localparam int USC_BAUD1 = 19200;
	localparam int USC_BAUD2 = 38400;
	localparam int USC_BAUD3 = 57600;
	localparam int USC_BAUD4 = 76800;
	localparam int USC_BAUD5 = 115200;
	localparam int USC_ADDR_W = 8;
	localparam logic [7:0] USC_OFS_FORMAT = 8'h00;
	localparam logic [7:0] USC_OFS_DUPLEX = 8'h04;
	localparam logic [7:0] USC_OFS_FLOW = 8'h08;
	localparam logic [7:0] USC_OFS_CTRL = 8'h0C;
	localparam logic [7:0] USC_OFS_STATUS = 8'h10;
	localparam logic [7:0] USC_OFS_MASK = 8'h14;
	localparam logic [7:0] USC_OFS_TXDATA = 8'h18;
	localparam logic [7:0] USC_OFS_RXDATA = 8'h1C;
	localparam logic [7:0] USC_OFS_INFO = 8'h20;
	localparam logic [31:0] USC_RST_FORMAT = 32'h28100000;
	localparam logic [31:0] USC_RST_DUPLEX = 32'h00000001;
	localparam logic [31:0] USC_RST_FLOW = 32'h01118040;
	localparam int USC_RXBUF_DEPTH = 64;
	localparam logic [8:0] USC_RXBUF_SIZE = 9'h040;
	localparam logic [7:0] USC_RXBUF_QUARTER = 8'h10;
	localparam logic [7:0] USC_XON = 8'h11;
	localparam logic [7:0] USC_XOFF = 8'h13;
	localparam int USC_EV_RX = 0;
	localparam int USC_EV_TXDONE = 1;
	localparam int USC_EV_OVERRUN = 2;
	localparam int USC_EV_PARITY = 3;
	localparam int USC_EV_FRAME = 4;
	localparam int USC_EV_W = 5;
	localparam logic [1:0] USC_RESP_OKAY = 2'h0;
	localparam logic [1:0] USC_RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic active;
		logic d8;
		logic par_en;
		logic par_odd;
		logic two_stop;
		logic half;
		logic full;
		logic cts_chk;
		logic fc_xon;
		logic fc_hw;
	} usc_cfg_t;
	typedef struct packed {
		logic [3:0] len;
		logic [11:0] bits;
	} usc_frame_t;
endpackage : usc_pkg

// ### hdl/usc_top.sv
// user serial channel: axi4-lite registers, transmitter, receiver, flow control
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module usc_top import usc_pkg::*; #(
	parameter int MS_CYCLES = USC_MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [USC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [USC_ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic serial_rxd,
	output logic serial_txd,
	input wire logic cts_n,
	output logic rts_n,
	output logic irq
);
	typedef enum logic {TX_IDLE, TX_RUN} usc_tx_state_t;
	typedef enum logic {RX_IDLE, RX_RUN} usc_rx_state_t;

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	function automatic logic [15:0] baud_div(input logic [3:0] code);
		int r;
		case (code)
			4'h1: r = USC_CLK_HZ / USC_BAUD1;
			4'h2: r = USC_CLK_HZ / USC_BAUD2;
			4'h3: r = USC_CLK_HZ / USC_BAUD3;
			4'h4: r = USC_CLK_HZ / USC_BAUD4;
			4'h5: r = USC_CLK_HZ / USC_BAUD5;
			default: r = USC_CLK_HZ / USC_BAUD0;
		endcase
		return r[15:0];
	endfunction

	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic par_of(input logic [7:0] d, input usc_cfg_t c);
		return (c.d8 ? ^d : ^d[6:0]) ^ c.par_odd;
	endfunction

	function automatic usc_frame_t make_frame(input logic [7:0] d, input usc_cfg_t c);
		usc_frame_t f;
		f.bits = 12'hFFF;
		f.bits[0] = 1'b0;
		f.bits[7:1] = d[6:0];
		if (c.d8) begin
			f.bits[8] = d[7];
		end
		if (c.par_en) begin
			f.bits[c.d8 ? 9 : 8] = par_of(d, c);
		end
		f.len = 4'h9 + {3'h0, c.d8} + {3'h0, c.par_en} + {3'h0, c.two_stop};
		return f;
	endfunction

	//------------------------------------------------------------
	// registers and decode
	//------------------------------------------------------------
	logic [31:0] fmt_word;
	logic [31:0] dup_word;
	logic [31:0] flow_word;
	logic port_open;
	logic [USC_EV_W-1:0] stat;
	logic [USC_EV_W-1:0] mask;
	logic [USC_EV_W-1:0] ev_set;
	logic [7:0] tx_data;
	logic tx_full;
	usc_cfg_t cfg;
	// reserved nibbles are kept in storage and read back, but no decode below uses them
	assign cfg.active = fmt_word[3:0] == 4'h1;
	assign cfg.d8 = fmt_word[27:24] == 4'h8;
	assign cfg.two_stop = fmt_word[23:20] == 4'h2;
	assign cfg.par_en = fmt_word[19:16] == 4'h1 || fmt_word[19:16] == 4'h2;
	assign cfg.par_odd = fmt_word[19:16] == 4'h1;
	assign cfg.half = dup_word[15:12] == 4'h1;
	assign cfg.full = dup_word[15:12] == 4'h0;
	assign cfg.cts_chk = dup_word[11:8] == 4'h1;
	assign cfg.fc_xon = cfg.full && flow_word[31:28] == 4'h1;
	assign cfg.fc_hw = cfg.full && flow_word[31:28] == 4'h2;
	wire [15:0] div = baud_div(fmt_word[31:28]);
	wire [7:0] hi_raw = flow_word[15:8];
	wire [7:0] lo_raw = flow_word[7:0];
	wire thr_bad = ({1'b0, lo_raw} + {1'b0, hi_raw}) >= USC_RXBUF_SIZE;
	wire [7:0] thr_hi = thr_bad ? USC_RXBUF_QUARTER : hi_raw;
	wire [7:0] thr_lo = thr_bad ? USC_RXBUF_QUARTER : lo_raw;

	//------------------------------------------------------------
	// axi4-lite slave
	//------------------------------------------------------------
	logic aw_got;
	logic w_got;
	logic [USC_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire wr_go = aw_got && w_got && !s_axi_bvalid;
	wire wr_fmt = wr_go && aw_addr == USC_OFS_FORMAT;
	wire wr_dup = wr_go && aw_addr == USC_OFS_DUPLEX;
	wire wr_flow = wr_go && aw_addr == USC_OFS_FLOW;
	wire wr_ctrl = wr_go && aw_addr == USC_OFS_CTRL && w_strb[0];
	wire wr_stat = wr_go && aw_addr == USC_OFS_STATUS && w_strb[0];
	wire wr_mask = wr_go && aw_addr == USC_OFS_MASK && w_strb[0];
	wire wr_tx = wr_go && aw_addr == USC_OFS_TXDATA && w_strb[0];
	wire wr_known = aw_addr <= USC_OFS_TXDATA && aw_addr[1:0] == 2'h0;
	wire soft_rst = wr_ctrl && w_data[1];
	wire rd_go = s_axi_arvalid && s_axi_arready;
	wire rd_pop;
	logic [6:0] rx_count;
	logic [7:0] rx_head;
	logic tx_busy;
	logic tx_en;
	logic stop_req;
	logic [31:0] rd_val;
	logic rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		if (s_axi_araddr == USC_OFS_FORMAT) begin
			rd_val = fmt_word;
		end else if (s_axi_araddr == USC_OFS_DUPLEX) begin
			rd_val = dup_word;
		end else if (s_axi_araddr == USC_OFS_FLOW) begin
			rd_val = flow_word;
		end else if (s_axi_araddr == USC_OFS_CTRL) begin
			rd_val = {31'h0, port_open};
		end else if (s_axi_araddr == USC_OFS_STATUS) begin
			rd_val = {27'h0, stat};
		end else if (s_axi_araddr == USC_OFS_MASK) begin
			rd_val = {27'h0, mask};
		end else if (s_axi_araddr == USC_OFS_TXDATA) begin
			rd_val = {24'h0, tx_data};
		end else if (s_axi_araddr == USC_OFS_RXDATA) begin
			rd_val = {23'h0, rx_count != 7'h0, rx_head};
		end else if (s_axi_araddr == USC_OFS_INFO) begin
			rd_val = {20'h0, stop_req, tx_en, tx_busy, tx_full, 1'b0, rx_count};
		end else begin
			rd_val = 32'h0;
			rd_ok = 1'b0;
		end
	end
	assign rd_pop = rd_go && s_axi_araddr == USC_OFS_RXDATA && rx_count != 7'h0;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= USC_RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else begin
			// no new address or data while a response is still waiting
			s_axi_awready <= !aw_got && !(s_axi_awvalid && s_axi_awready) && !wr_go &&
				!s_axi_bvalid;
			s_axi_wready <= !w_got && !(s_axi_wvalid && s_axi_wready) && !wr_go &&
				!s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? USC_RESP_OKAY : USC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= USC_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? USC_RESP_OKAY : USC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			fmt_word <= USC_RST_FORMAT;
			dup_word <= USC_RST_DUPLEX;
			flow_word <= USC_RST_FLOW;
			port_open <= 1'b0;
			mask <= '0;
			stat <= '0;
			irq <= 1'b0;
		end else begin
			if (wr_fmt) begin
				fmt_word <= strb_merge(fmt_word, w_data, w_strb);
			end
			if (wr_dup) begin
				dup_word <= strb_merge(dup_word, w_data, w_strb);
			end
			if (wr_flow) begin
				flow_word <= strb_merge(flow_word, w_data, w_strb);
			end
			if (wr_ctrl) begin
				port_open <= w_data[0];
			end
			if (wr_mask) begin
				mask <= w_data[USC_EV_W-1:0];
			end
			// a new event beats a write-one-to-clear in the same cycle
			stat <= (stat & ~(wr_stat ? w_data[USC_EV_W-1:0] : '0)) | ev_set;
			irq <= |(((stat & ~(wr_stat ? w_data[USC_EV_W-1:0] : '0)) | ev_set) & mask);
		end
	end

	//------------------------------------------------------------
	// millisecond timers: 0 = character gap, 1 = turnaround
	//------------------------------------------------------------
	logic [1:0] tmr_load;
	logic [7:0] tmr_val [2];
	logic [1:0] tmr_busy;
	logic tx_char_done;
	logic rx_char_done;
	assign tmr_load[0] = tx_char_done;
	assign tmr_val[0] = {4'h0, dup_word[19:16]};
	assign tmr_load[1] = rx_char_done && cfg.half;
	assign tmr_val[1] = dup_word[7:0];
	for (genvar g = 0; g < 2; g++) begin : gen_tmr
		logic [17:0] ms_cnt;
		logic [7:0] left;
		assign tmr_busy[g] = left != 8'h0;
		always_ff @(posedge ref_clk) begin
			if (!rstn || soft_rst) begin
				ms_cnt <= 18'h0;
				left <= 8'h0;
			end else if (tmr_load[g]) begin
				ms_cnt <= 18'h0;
				left <= tmr_val[g];
			end else if (left != 8'h0) begin
				if (ms_cnt == 18'(MS_CYCLES - 1)) begin
					ms_cnt <= 18'h0;
					left <= left - 8'h1;
				end else begin
					ms_cnt <= ms_cnt + 18'h1;
				end
			end
		end
	end

	//------------------------------------------------------------
	// flow control state
	//------------------------------------------------------------
	logic ctl_pend;
	logic [7:0] ctl_char;
	logic rst_xon;
	logic port_open_d;
	logic rx_xon_seen;
	logic rx_xoff_seen;
	logic tx_take_ctl;
	logic tx_take_rxon;
	logic tx_take_dat;
	// stop while at or above high, release only at or below low
	wire next_stop_req = ({1'b0, rx_count} >= thr_hi) ? 1'b1 :
		(({1'b0, rx_count} <= thr_lo) ? 1'b0 : stop_req);
	wire open_rise = port_open && !port_open_d;
	wire open_fall = !port_open && port_open_d;
	wire close_ctl = cfg.fc_xon && open_fall &&
		(flow_word[19:16] == 4'h1 || flow_word[19:16] == 4'h2);
	wire thr_ctl = cfg.fc_xon && next_stop_req != stop_req;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			stop_req <= 1'b0;
			port_open_d <= 1'b0;
			tx_en <= 1'b1;
			ctl_pend <= 1'b0;
			ctl_char <= USC_XON;
			rst_xon <= 1'b0;
			rts_n <= 1'b0;
		end else begin
			stop_req <= next_stop_req;
			port_open_d <= port_open;
			rts_n <= cfg.fc_hw && next_stop_req;
			if (soft_rst) begin
				tx_en <= 1'b1;
				rst_xon <= cfg.fc_xon && flow_word[27:24] == 4'h1;
			end else if (tx_take_rxon) begin
				rst_xon <= 1'b0;
			end
			if (open_rise && cfg.fc_xon) begin
				tx_en <= flow_word[23:20] == 4'h1;
			end else if (rx_xoff_seen) begin
				tx_en <= 1'b0;
			end else if (rx_xon_seen) begin
				tx_en <= 1'b1;
			end
			// the newest request wins the single slot
			if (close_ctl) begin
				ctl_pend <= 1'b1;
				ctl_char <= flow_word[19:16] == 4'h1 ? USC_XON : USC_XOFF;
			end else if (thr_ctl) begin
				ctl_pend <= 1'b1;
				ctl_char <= next_stop_req ? USC_XOFF : USC_XON;
			end else if (tx_take_ctl || soft_rst) begin
				ctl_pend <= 1'b0;
			end
		end
	end

	//------------------------------------------------------------
	// transmitter
	//------------------------------------------------------------
	usc_tx_state_t tx_state;
	usc_frame_t tx_frame;
	logic [3:0] tx_left;
	logic [15:0] tx_cnt;
	wire cts_need = (cfg.half && cfg.cts_chk) || cfg.fc_hw;
	wire cts_ok = !cts_need || !cts_n;
	wire tx_gate = cfg.active && tx_state == TX_IDLE && !tmr_busy[0] &&
		!(cfg.half && tmr_busy[1]);
	assign tx_take_ctl = tx_gate && ctl_pend && cfg.fc_xon;
	assign tx_take_rxon = tx_gate && !tx_take_ctl && rst_xon && tx_en && cfg.fc_xon;
	assign tx_take_dat = tx_gate && !tx_take_ctl && !tx_take_rxon && tx_full && port_open &&
		cts_ok && (!cfg.fc_xon || tx_en);
	wire [7:0] tx_pick = tx_take_ctl ? ctl_char : (tx_take_rxon ? USC_XON : tx_data);
	wire usc_frame_t tx_new = make_frame(tx_pick, cfg);
	assign tx_busy = tx_state == TX_RUN;
	always_ff @(posedge ref_clk) begin
		if (!rstn || soft_rst) begin
			tx_state <= TX_IDLE;
			tx_frame <= '0;
			tx_left <= 4'h0;
			tx_cnt <= 16'h0;
			serial_txd <= 1'b1;
			tx_char_done <= 1'b0;
			tx_full <= 1'b0;
			tx_data <= 8'h0;
		end else begin
			tx_char_done <= 1'b0;
			if (wr_tx && !tx_full) begin
				tx_full <= 1'b1;
				tx_data <= w_data[7:0];
			end else if (tx_take_dat) begin
				tx_full <= 1'b0;
			end
			case (tx_state)
				TX_IDLE: begin
					serial_txd <= 1'b1;
					if (tx_take_ctl || tx_take_rxon || tx_take_dat) begin
						tx_frame <= tx_new;
						tx_left <= tx_new.len;
						tx_cnt <= div - 16'h1;
						serial_txd <= 1'b0;
						tx_state <= TX_RUN;
					end
				end
				TX_RUN: begin
					if (tx_cnt != 16'h0) begin
						tx_cnt <= tx_cnt - 16'h1;
					end else if (tx_left == 4'h1) begin
						serial_txd <= 1'b1;
						tx_char_done <= 1'b1;
						tx_state <= TX_IDLE;
					end else begin
						tx_frame.bits <= {1'b1, tx_frame.bits[11:1]};
						serial_txd <= tx_frame.bits[1];
						tx_left <= tx_left - 4'h1;
						tx_cnt <= div - 16'h1;
					end
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	//------------------------------------------------------------
	// receiver and receive buffer
	//------------------------------------------------------------
	usc_rx_state_t rx_state;
	logic [11:0] rx_bits;
	logic [3:0] rx_idx;
	logic [15:0] rx_cnt;
	logic [7:0] rx_mem [USC_RXBUF_DEPTH];
	logic [5:0] rx_wp;
	logic [5:0] rx_rp;
	// samples: start, data, parity, first stop; a second stop is not checked
	wire [3:0] rx_last = 4'h8 + {3'h0, cfg.d8} + {3'h0, cfg.par_en};
	wire [11:0] rx_all = rx_bits | (12'h001 << rx_idx) & {12{serial_rxd}};
	wire [7:0] rx_byte = cfg.d8 ? rx_all[8:1] : {1'b0, rx_all[7:1]};
	wire rx_par_bad = cfg.par_en && (rx_all[cfg.d8 ? 9 : 8] != par_of(rx_byte, cfg));
	wire rx_end = rx_state == RX_RUN && rx_cnt == 16'h0 && rx_idx == rx_last;
	wire rx_ok = rx_end && serial_rxd && !rx_par_bad;
	wire rx_ctl = cfg.fc_xon && (rx_byte == USC_XON || rx_byte == USC_XOFF);
	wire rx_push = rx_ok && !rx_ctl && rx_count != USC_RXBUF_SIZE[6:0];
	assign rx_head = rx_mem[rx_rp];
	assign rx_xon_seen = rx_ok && cfg.fc_xon && rx_byte == USC_XON;
	assign rx_xoff_seen = rx_ok && cfg.fc_xon && rx_byte == USC_XOFF;
	assign ev_set[USC_EV_RX] = rx_push;
	assign ev_set[USC_EV_TXDONE] = tx_char_done;
	assign ev_set[USC_EV_OVERRUN] = rx_ok && !rx_ctl && !rx_push;
	assign ev_set[USC_EV_PARITY] = rx_end && rx_par_bad;
	assign ev_set[USC_EV_FRAME] = rx_end && !serial_rxd;
	always_ff @(posedge ref_clk) begin
		if (!rstn || soft_rst) begin
			rx_state <= RX_IDLE;
			rx_bits <= 12'h0;
			rx_idx <= 4'h0;
			rx_cnt <= 16'h0;
			rx_char_done <= 1'b0;
		end else begin
			rx_char_done <= rx_end;
			case (rx_state)
				RX_IDLE: begin
					if (cfg.active && !serial_rxd) begin
						rx_state <= RX_RUN;
						rx_cnt <= {1'b0, div[15:1]};
						rx_idx <= 4'h0;
						rx_bits <= 12'h0;
					end
				end
				RX_RUN: begin
					if (rx_cnt != 16'h0) begin
						rx_cnt <= rx_cnt - 16'h1;
					end else if ((rx_idx == 4'h0 && serial_rxd) || rx_end) begin
						// a glitch on the start bit is simply dropped
						rx_state <= RX_IDLE;
					end else begin
						rx_bits <= rx_all;
						rx_idx <= rx_idx + 4'h1;
						rx_cnt <= div - 16'h1;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn || soft_rst) begin
			rx_wp <= 6'h0;
			rx_rp <= 6'h0;
			rx_count <= 7'h0;
		end else begin
			if (rx_push) begin
				rx_mem[rx_wp] <= rx_byte;
				rx_wp <= rx_wp + 6'h1;
			end
			if (rd_pop) begin
				rx_rp <= rx_rp + 6'h1;
			end
			rx_count <= rx_count + {6'h0, rx_push} - {6'h0, rd_pop};
		end
	end
endmodule // usc_top
`default_nettype wire
